// [rtl/debug_trace_fifo_readout.sv]
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// How it works
// RULE_01: upper-byte register returns bits 15:8 of the oldest word; writes ignored.
// RULE_02: in event-only mode the upper-byte register always reads 0x00.
// RULE_03: reading the upper-byte register never moves the FIFO.
// RULE_04: lower-byte register returns bits 7:0, ignores writes, each read advances.
// RULE_05: event-only captures store eight bits in the low half, high half zero.
// RULE_06: software reads upper byte before lower byte for 16-bit words.
// RULE_07: byte-wide entries may be read by repeated lower-byte reads alone.
// RULE_08: while armed, lower-byte reads do not advance; software should not read.
// RULE_09: unarmed lower-byte read loads latest opcode address into last location.
// RULE_10: unarmed, the FIFO is an eight-deep delay line; ninth read returns first.
// RULE_11: profiling software primes with eight discarded reads, then reads periodically.
// RULE_12: entries are sixteen bits; output always shows the oldest unread entry.
module debug_trace_fifo_readout
   import trace_fifo_pkg::*;
#(
   parameter int unsigned DEPTH = TRACE_DEPTH,
   parameter int unsigned WIDTH = TRACE_WIDTH
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // capture logic, same clock
   input  wire logic              trace_armed_flag_i,
   input  wire logic              cap_valid_i,
   input  wire logic [WIDTH-1:0]  cap_data_i,
   input  wire logic [WIDTH-1:0]  opcode_addr_i,
   output logic                   event_only_o
);
   if (WIDTH != 16 || DEPTH < 2) begin : g_chk
      $error("readout needs 16-bit words and at least two entries");
   end

   // words[0] is the head; new words enter at words[DEPTH-1]
   logic [DEPTH-1:0][WIDTH-1:0] words;
   logic [WIDTH-1:0]            head;
   logic                        take;
   logic                        rd_upper;
   logic                        rd_lower;
   logic                        pop;
   logic                        cap_shift;
   logic                        shift;
   logic [WIDTH-1:0]            shift_din;

   logic                        ack_d;
   logic                        ack_q;
   logic [31:0]                 dat_d;
   logic [31:0]                 dat_q;
   logic                        event_only_d;
   logic                        event_only_q;

   assign head     = words[0]; // RULE_12
   // a request is taken once; the ack cycle itself never starts a second access
   assign take     = wb_cyc_i && wb_stb_i && !ack_q;
   assign rd_upper = take && !wb_we_i && (wb_adr_i == UPPER_BYTE_OFS);
   assign rd_lower = take && !wb_we_i && (wb_adr_i == LOWER_BYTE_OFS);

   // armed capture freezes read-out so the trace is not disturbed
   // an armed lower read is still acked and shows the head's low byte
   assign pop       = rd_lower && !trace_armed_flag_i; // RULE_04 RULE_08
   assign cap_shift = cap_valid_i && trace_armed_flag_i;
   assign shift     = pop || cap_shift;

   // a pop needs the flag low and a capture needs it high, so they never meet;
   // the priority below only fixes which source is named first
   always_comb begin
      if (pop) begin
         shift_din = opcode_addr_i; // RULE_09 RULE_10
      // event-only mode reshapes captures only; profiling keeps the full address
      end else if (event_only_q) begin
         shift_din = {UNUSED_BYTE, cap_data_i[7:0]}; // RULE_05
      end else begin
         shift_din = cap_data_i;
      end
   end

   trace_word_store #(
      .DEPTH (DEPTH),
      .WIDTH (WIDTH)
   ) u_store (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .shift_i (shift),
      .din_i   (shift_din),
      .words_o (words)
   );

   // register bus: one wait cycle, data and ack both registered
   always_comb begin
      ack_d        = take;
      dat_d        = dat_q;
      event_only_d = event_only_q;
      if (take && wb_we_i) begin
         dat_d = DAT_RESET;
         // data registers are read-only, writes there fall through
         if (wb_adr_i == TRACE_CTRL_OFS && wb_sel_i[0]) begin
            event_only_d = wb_dat_i[CTRL_EVENT_ONLY];
         end
      end else if (take) begin
         // the head is sampled at the taking edge, before a pop moves it
         dat_d = DAT_RESET;
         if (wb_adr_i == UPPER_BYTE_OFS) begin
            if (!event_only_q) begin
               dat_d[7:0] = head[15:8]; // RULE_01 RULE_03
            end else begin
               dat_d[7:0] = UNUSED_BYTE; // RULE_02
            end
         end else if (wb_adr_i == LOWER_BYTE_OFS) begin
            dat_d[7:0] = head[7:0]; // RULE_04
         end else if (wb_adr_i == TRACE_CTRL_OFS) begin
            dat_d[CTRL_EVENT_ONLY] = event_only_q;
         end else if (wb_adr_i == TRACE_STAT_OFS) begin
            dat_d[STAT_ARMED]      = trace_armed_flag_i;
            dat_d[STAT_EVENT_ONLY] = event_only_q;
         end
      end
   end

   // every bus output leaves a flip-flop, so no decode glitch reaches the master
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q        <= 1'b0;
         dat_q        <= DAT_RESET;
         event_only_q <= CTRL_RESET;
      end else begin
         ack_q        <= ack_d;
         dat_q        <= dat_d;
         event_only_q <= event_only_d;
      end
   end

   assign wb_ack_o     = ack_q;
   assign wb_dat_o     = dat_q;
   assign event_only_o = event_only_q;

   // bus and store checks, all on the rising edge and quiet during reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_upper_read_data: assert property ( // RULE_01
      rd_upper && !event_only_q |=> wb_ack_o && wb_dat_o == {24'h0, $past(head[15:8])})
      else $error("upper byte read returned wrong data");

   a_upper_event_zero: assert property ( // RULE_02
      rd_upper && event_only_q |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("upper byte not zero in event-only mode");

   a_upper_no_advance: assert property ( // RULE_03
      rd_upper && !trace_armed_flag_i |=> $stable(head))
      else $error("upper byte read moved the fifo");

   a_lower_read_pops: assert property ( // RULE_04
      pop |=> head == $past(words[1]) && wb_dat_o == {24'h0, $past(head[7:0])})
      else $error("lower byte read did not advance");

   a_event_low_half: assert property ( // RULE_05
      cap_shift && event_only_q |=> words[DEPTH-1][15:8] == 8'h00)
      else $error("event-only capture filled high half");

   a_armed_no_advance: assert property ( // RULE_08
      rd_lower && trace_armed_flag_i && !cap_valid_i |=> $stable(words))
      else $error("armed lower read moved the fifo");

   a_opcode_capture: assert property ( // RULE_09
      pop |=> words[DEPTH-1] == $past(opcode_addr_i))
      else $error("opcode address not captured on lower read");

   a_delay_line: assert property ( // RULE_10
      pop |=> words[DEPTH-2] == $past(words[DEPTH-1]))
      else $error("delay line did not shift toward head");

   a_ack_single: assert property (
      take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");

   a_lower_read_data: assert property ( // RULE_04
      rd_lower |=> wb_ack_o && wb_dat_o == {24'h0, $past(head[7:0])})
      else $error("lower byte read returned wrong data");

   a_write_no_shift: assert property ( // RULE_01
      take && wb_we_i && !cap_shift |=> $stable(words))
      else $error("register write moved the fifo");

   a_write_reads_zero: assert property ( // RULE_04
      take && wb_we_i |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("write answer carried data");

   a_capture_entry: assert property ( // RULE_12
      cap_shift && !event_only_q |=> words[DEPTH-1] == $past(cap_data_i))
      else $error("captured word not stored whole");

   a_event_low_byte: assert property ( // RULE_05
      cap_shift && event_only_q |=> words[DEPTH-1][7:0] == $past(cap_data_i[7:0]))
      else $error("event-only capture lost its low byte");

   a_unarmed_capture_off: assert property (
      cap_valid_i && !trace_armed_flag_i && !pop |=> $stable(words))
      else $error("capture accepted while unarmed");

   a_status_read_data: assert property (
      take && !wb_we_i && wb_adr_i == TRACE_STAT_OFS |=>
         wb_dat_o == {30'h0, $past(event_only_q), $past(trace_armed_flag_i)})
      else $error("status read returned wrong data");

   a_ack_needs_take: assert property (
      wb_ack_o |-> $past(take))
      else $error("ack without a taken request");

   // scenarios the bench reaches, except c_upper_then_lower: its lower read comes three cycles after the upper
   c_profile_pop: cover property (pop ##[1:20] pop);
   c_event_upper_read: cover property (rd_upper && event_only_q);
   c_upper_then_lower: cover property (rd_upper ##2 rd_lower);
   c_armed_read: cover property (rd_lower && trace_armed_flag_i);
   c_event_capture: cover property (cap_shift && event_only_q);
endmodule

// [rtl/trace_fifo_pkg.sv]
package trace_fifo_pkg;
   // word-aligned byte offsets on the register bus
   localparam int unsigned ADR_W           = 4;
   localparam logic [3:0]  UPPER_BYTE_OFS  = 4'h0;
   localparam logic [3:0]  LOWER_BYTE_OFS  = 4'h4;
   localparam logic [3:0]  TRACE_CTRL_OFS  = 4'h8;
   localparam logic [3:0]  TRACE_STAT_OFS  = 4'hC;
   // field positions
   localparam int unsigned CTRL_EVENT_ONLY = 0;
   localparam int unsigned STAT_ARMED      = 0;
   localparam int unsigned STAT_EVENT_ONLY = 1;
   // values after reset, and the fill for unused bytes
   localparam logic        CTRL_RESET      = 1'b0;
   localparam logic [31:0] DAT_RESET       = 32'h0000_0000;
   localparam logic [7:0]  UNUSED_BYTE     = 8'h00;
   // geometry defaults
   localparam int unsigned TRACE_DEPTH     = 8;
   localparam int unsigned TRACE_WIDTH     = 16;
endpackage

// [rtl/trace_word_store.sv]
`timescale 1ns/10ps
// shift store: entry 0 is the oldest word, new words enter at the last entry
module trace_word_store
   import trace_fifo_pkg::*;
#(
   parameter int unsigned DEPTH = TRACE_DEPTH,
   parameter int unsigned WIDTH = TRACE_WIDTH
) (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // shift request
   input  wire logic                         shift_i,
   input  wire logic [WIDTH-1:0]             din_i,
   // contents
   output logic      [DEPTH-1:0][WIDTH-1:0]  words_o
);
   logic [DEPTH-1:0][WIDTH-1:0] words_d;
   logic [DEPTH-1:0][WIDTH-1:0] words_q;

   if (DEPTH < 2) begin : g_chk
      $error("trace_word_store needs at least two entries");
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
         words_d[i] = words_q[i];
         if (shift_i) begin
            words_d[i] = (i == DEPTH - 1) ? din_i : words_q[(i + 1) % DEPTH];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         words_q <= '0;
      end else begin
         words_q <= words_d;
      end
   end

   assign words_o = words_q;
endmodule

// [verification/test_debug_trace_fifo_readout.sv]
`timescale 1ns/10ps
module test_debug_trace_fifo_readout;
   import trace_fifo_pkg::*;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              wb_cyc_i = 1'b0;
   logic              wb_stb_i = 1'b0;
   logic              wb_we_i = 1'b0;
   logic [ADR_W-1:0]  wb_adr_i = '0;
   logic [3:0]        wb_sel_i = 4'hF;
   logic [31:0]       wb_dat_i = 32'h0;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o;
   logic              trace_armed_flag_i = 1'b0;
   logic              cap_valid_i = 1'b0;
   logic [15:0]       cap_data_i = 16'h0;
   logic [15:0]       opcode_addr_i = 16'h0;
   logic              event_only_o;
   logic [15:0]       m [8] = '{default: 16'h0};
   logic [31:0]       q;
   logic [15:0]       w;
   int                n_mismatch = 0;
   int                cmp_count = 0;

   debug_trace_fifo_readout u_debug_trace_fifo_readout (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .trace_armed_flag_i, .cap_valid_i, .cap_data_i, .opcode_addr_i, .event_only_o);

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // holds the request until ack is sampled high, then releases it
   task automatic bus(input logic [3:0] a, input logic we, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   task automatic shift(input logic [15:0] v);
      for (int i = 0; i < 7; i++) begin
         m[i] = m[i+1];
      end
      m[7] = v;
   endtask

   task automatic push(input logic [15:0] v);
      @(posedge clk_i);
      cap_valid_i <= 1'b1;
      cap_data_i  <= v;
      @(posedge clk_i);
      cap_valid_i <= 1'b0;
   endtask

   task automatic hi(input logic ev);
      bus(UPPER_BYTE_OFS, 1'b0, 32'h0);
      chk(q, ev ? {24'h0, UNUSED_BYTE} : {24'h0, m[0][15:8]});
   endtask

   // a lower read moves the model only while unarmed
   task automatic lo;
      bus(LOWER_BYTE_OFS, 1'b0, 32'h0);
      chk(q, {24'h0, m[0][7:0]});
      if (trace_armed_flag_i !== 1'b1) begin
         shift(opcode_addr_i);
      end
   endtask

   initial begin
      void'($urandom(65));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         opcode_addr_i <= 16'($urandom);
         if (i == 8) begin
            bus(UPPER_BYTE_OFS, 1'b1, $urandom);
            bus(LOWER_BYTE_OFS, 1'b1, $urandom);
         end
         hi(1'b0);
         lo();
      end
      $display("test profiling done");
      trace_armed_flag_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         w = 16'($urandom);
         push(w);
         shift(w);
      end
      lo();
      lo();
      bus(TRACE_STAT_OFS, 1'b0, 32'h0);
      chk(q, 32'h1);
      trace_armed_flag_i <= 1'b0;
      push(16'hFFFF);
      for (int i = 0; i < 8; i++) begin
         hi(1'b0);
         lo();
      end
      $display("test armed capture done");
      bus(TRACE_CTRL_OFS, 1'b1, 32'h1, 4'hE);
      chk({31'h0, event_only_o}, 32'h0);
      bus(TRACE_CTRL_OFS, 1'b1, 32'h1);
      chk({31'h0, event_only_o}, 32'h1);
      bus(TRACE_CTRL_OFS, 1'b0, 32'h0);
      chk(q, 32'h1);
      trace_armed_flag_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         w = 16'($urandom);
         push(w);
         shift({UNUSED_BYTE, w[7:0]});
      end
      bus(TRACE_STAT_OFS, 1'b0, 32'h0);
      chk(q, 32'h3);
      trace_armed_flag_i <= 1'b0;
      hi(1'b1);
      for (int i = 0; i < 8; i++) begin
         lo();
      end
      bus(4'h2, 1'b0, 32'h0);
      chk(q, 32'h0);
      $display("test event only done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      m = '{default: 16'h0};
      chk({31'h0, event_only_o}, 32'h0);
      lo();
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule
